// ### csp_defines.vh
`ifndef CSP_DEFINES_VH
`define CSP_DEFINES_VH
// ----------------------------------------------------------------
// Serial framing constants
// ----------------------------------------------------------------
`define CSP_BITS_PER_BYTE   4'h8
`define CSP_BIT_LAST        3'h7
`define CSP_BYTE_CNT_W      8
`define CSP_XFER_BYTES_DEF  8'h04
// ----------------------------------------------------------------
// Transfer state encodings
// ----------------------------------------------------------------
`define CSP_ST_IDLE         2'h0
`define CSP_ST_WAIT         2'h1
`define CSP_ST_XFER         2'h2
`define CSP_ST_DONE         2'h3
`endif

// ### csp_sync2.v
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two-flop synchroniser for pin inputs, width set by parameter.
// ----------------------------------------------------------------
module csp_sync2 #(
    parameter W = 1
) (
    input  wire         i_mclk,     // System clock.
    input  wire         i_sys_rst,  // Synchronous reset, active high.
    input  wire [W-1:0] i_async,    // Asynchronous inputs.
    input  wire [W-1:0] i_rst_val,  // Constant value held under reset.
    output wire [W-1:0] o_sync      // Synchronised outputs.
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    // First stage is read only by the second stage.
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            meta_reg <= i_rst_val;
            sync_reg <= i_rst_val;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule // csp_sync2

// ### csp_port.v
`timescale 1ns/1ps
`include "csp_defines.vh"
// Summary of operation
// RL1 - Chain in low at byte end starts transfer
// RL2 - After last byte, release output, ignore input
// RL3 - Chain in sampled on serial clock rise
// RL4 - Unchained systems tie chain in low
// RL5 - Chain out low during final bit
// RL6 - Chain out changes after clock rise
// RL7 - Select fall with chain in low enables
// RL8 - Select high: no input, output released
// RL9 - Input bits captured on clock fall
// RL10 - Output bits launched on clock rise
// RL11 - Host idles serial clock high
// RL12 - Chain in fall under select enables output
// RL13 - Fault output low on input fault
// RL14 - Overflow low on over range or fault
// RL15 - Crystal enabled: clock output buffers oscillator; the code also requires i_crystal_fitted high
// RL16 - Crystal disabled: clock output released
// RL17 - Bit counter resets on select fall
module csp_port #(
    parameter XFER_BYTES = `CSP_XFER_BYTES_DEF  // Bytes moved per transfer.
) (
    input  wire       i_mclk,              // 100 MHz system clock.
    input  wire       i_sys_rst,           // Synchronous reset, active high.
    input  wire       i_sclk,              // Serial clock pin.
    input  wire       i_cs_n,              // Chip select pin, active low.
    input  wire       i_din,               // Serial data input pin.
    input  wire       i_chain_in_n,        // Cascade input pin, active low.
    input  wire       i_cmd_start,         // Core: a new command was decoded.
    input  wire [7:0] i_tx_byte,           // Core: byte to shift out.
    output reg        o_tx_take,           // Core: tx byte loaded, one pulse.
    output reg  [7:0] o_rx_byte,           // Core: received byte.
    output reg        o_rx_valid,          // Core: rx byte valid, one pulse.
    output reg        o_dout,              // Serial data output value.
    output reg        o_dout_oe,           // Serial output driver enable.
    output reg        o_chain_out_n,       // Cascade output, active low.
    input  wire       i_input_fault,       // Any analog input out of window.
    input  wire       i_result_over_range, // Any result past full scale.
    output wire       o_fault_n_o,         // Fault pin output value.
    output wire       o_fault_n_oe,        // Fault pin pull-down enable.
    output wire       o_result_over_range_n_o,  // Overflow pin output value.
    output wire       o_result_over_range_n_oe, // Overflow pin pull-down enable.
    input  wire       i_osc_clk,           // Internal oscillator clock.
    input  wire       i_crystal_enable,    // Crystal-enable config bit.
    input  wire       i_crystal_fitted,    // Crystal present strap.
    output wire       o_buffered_osc_out,  // Clock output pin value.
    output wire       o_buffered_osc_out_oe // Clock output pin enable.
);
    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    wire [3:0] pins_sync;
    csp_sync2 #(.W(4)) u_sync (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_sclk, i_cs_n, i_din, i_chain_in_n}),
        .i_rst_val (4'hc),
        .o_sync    (pins_sync)
    );
    wire sclk_s  = pins_sync[3];
    wire cs_n_s  = pins_sync[2];
    wire din_s   = pins_sync[1];
    wire chain_s = pins_sync[0];

    reg sclk_d_reg;
    reg cs_d_reg;
    reg chain_d_reg;

    // Delayed copies for edge detection; clock and select reset high, chain low.
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            sclk_d_reg  <= 1'b1;
            cs_d_reg    <= 1'b1;
            chain_d_reg <= 1'b0;
        end else begin
            sclk_d_reg  <= sclk_s;
            cs_d_reg    <= cs_n_s;
            chain_d_reg <= chain_s;
        end
    end

    wire sclk_rise  = sclk_s & ~sclk_d_reg;
    wire sclk_fall  = ~sclk_s & sclk_d_reg;
    wire cs_fall    = ~cs_n_s & cs_d_reg;
    wire chain_fall = ~chain_s & chain_d_reg;

    // ----------------------------------------------------------------
    // Transfer sequencing
    // ----------------------------------------------------------------
    reg [1:0] state_reg;
    reg [2:0] bit_reg;
    reg [`CSP_BYTE_CNT_W-1:0] byte_reg;
    reg [7:0] rx_sh_reg;
    reg [7:0] tx_sh_reg;

    wire last_bit = (bit_reg == `CSP_BIT_LAST);
    wire last_byte = (byte_reg == XFER_BYTES - 1'b1);

    // Active only while selected and in transfer; the host keeps the
    // clock idle high, so the first edge of a byte is a fall. [RL11]
    wire active = ~cs_n_s & (state_reg == `CSP_ST_XFER);

    // Main sequencer: counter, shifting and ownership hand-over.
    always @(posedge i_mclk) begin
        o_tx_take  <= 1'b0;
        o_rx_valid <= 1'b0;
        if (i_sys_rst) begin
            state_reg      <= `CSP_ST_IDLE;
            bit_reg        <= 3'h0;
            byte_reg       <= {`CSP_BYTE_CNT_W{1'b0}};
            rx_sh_reg      <= 8'h00;
            tx_sh_reg      <= 8'h00;
            o_rx_byte      <= 8'h00;
            o_dout         <= 1'b0;
            o_dout_oe      <= 1'b0;
            o_chain_out_n  <= 1'b1;
        end else if (cs_n_s) begin
            // Deselected: no input accepted, output released. [RL8]
            state_reg     <= `CSP_ST_IDLE;
            o_dout_oe     <= 1'b0;
            o_chain_out_n <= 1'b1;
            bit_reg       <= 3'h0;
        end else begin
            if (cs_fall) begin
                bit_reg  <= 3'h0;                        // [RL17]
                byte_reg <= {`CSP_BYTE_CNT_W{1'b0}};
                if (!chain_s) begin
                    // The first bit must stand before the first fall. [RL10]
                    state_reg <= `CSP_ST_XFER;           // [RL7]
                    o_dout_oe <= 1'b1;
                    o_dout    <= i_tx_byte[7];
                    tx_sh_reg <= {i_tx_byte[6:0], 1'b0};
                    o_tx_take <= 1'b1;
                end else begin
                    state_reg <= `CSP_ST_WAIT;
                end
            end else begin
                case (state_reg)
                `CSP_ST_WAIT: begin
                    // Falling chain input enables the driver early. [RL12]
                    if (chain_fall)
                        o_dout_oe <= 1'b1;
                    // Chain sampled at the rise ending a byte. [RL3]
                    if (sclk_rise && last_bit && !chain_s) begin
                        state_reg <= `CSP_ST_XFER;       // [RL1]
                        o_dout_oe <= 1'b1;
                        byte_reg  <= {`CSP_BYTE_CNT_W{1'b0}};
                        o_dout    <= i_tx_byte[7];       // [RL10]
                        tx_sh_reg <= {i_tx_byte[6:0], 1'b0};
                        o_tx_take <= 1'b1;
                    end
                end
                `CSP_ST_DONE: begin
                    // Released until a new command restarts us. [RL2]
                    o_dout_oe <= 1'b0;
                    if (i_cmd_start)
                        state_reg <= `CSP_ST_WAIT;
                end
                default: begin
                end
                endcase
                if (sclk_fall && (active || state_reg != `CSP_ST_DONE)) begin
                    // Data in on the falling edge. [RL9]
                    if (active)
                        rx_sh_reg <= {rx_sh_reg[6:0], din_s};
                    if (active && last_bit) begin
                        o_rx_byte  <= {rx_sh_reg[6:0], din_s};
                        o_rx_valid <= 1'b1;
                    end
                end
                if (sclk_rise) begin
                    bit_reg <= bit_reg + 3'h1;           // [RL17]
                    if (active) begin
                        // Data out on the rising edge. [RL10]
                        o_dout         <= tx_sh_reg[7];
                        tx_sh_reg      <= {tx_sh_reg[6:0], 1'b0};
                        // Chain out low over the final bit, after the rise. [RL5] [RL6]
                        o_chain_out_n  <= ~(last_byte && bit_reg == 3'h6);
                        if (last_bit) begin
                            if (last_byte) begin
                                state_reg <= `CSP_ST_DONE;  // [RL2]
                                o_dout_oe <= 1'b0;
                            end else begin
                                // The rise ending a byte launches the next MSB.
                                byte_reg  <= byte_reg + 1'b1;
                                o_dout    <= i_tx_byte[7];  // [RL10]
                                tx_sh_reg <= {i_tx_byte[6:0], 1'b0};
                                o_tx_take <= 1'b1;
                            end
                        end
                    end else begin
                        o_chain_out_n <= 1'b1;           // [RL6]
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Open-drain status pins and clock output
    // ----------------------------------------------------------------
    reg fault_reg;
    reg ovr_reg;

    // Status levels registered; wire-NOR so only pull low. [RL13] [RL14]
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            fault_reg <= 1'b0;
            ovr_reg   <= 1'b0;
        end else begin
            fault_reg <= i_input_fault;
            ovr_reg   <= i_result_over_range | i_input_fault;
        end
    end

    assign o_fault_n_o              = 1'b0;
    assign o_fault_n_oe             = fault_reg;           // [RL13]
    assign o_result_over_range_n_o  = 1'b0;
    assign o_result_over_range_n_oe = ovr_reg | fault_reg; // [RL14]

    // Clock buffer is combinational: a registered copy would halve it.
    assign o_buffered_osc_out    = i_osc_clk;              // [RL15]
    assign o_buffered_osc_out_oe = i_crystal_enable & i_crystal_fitted; // [RL15] [RL16]
endmodule // csp_port

// ### csp_port_checker.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Pin checks for the serial port, bound to every port instance.
// ----------------------------------------------------------------
module csp_port_checker (
    input wire i_mclk, i_sys_rst, i_sclk, i_cs_n, i_input_fault,
    input wire i_result_over_range, i_osc_clk, i_crystal_enable,
    input wire i_crystal_fitted, o_dout_oe, o_chain_out_n, o_rx_valid,
    input wire o_fault_n_o, o_fault_n_oe, o_result_over_range_n_oe,
    input wire o_result_over_range_n_o,
    input wire o_buffered_osc_out, o_buffered_osc_out_oe
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    // Pins pass a synchroniser, so a few cycles of lag are allowed.
    cs_high_quiet_a: assert property (i_cs_n [*5] |-> !o_dout_oe && !o_rx_valid)
        else $error("port active while deselected");
    chain_after_rise_a: assert property ($changed(o_chain_out_n) |->
        $past(i_sclk, 1) && $past(i_sclk, 2)) else $error("chain output moved off a rise");
    chain_low_span_a: assert property ($fell(o_chain_out_n) |->
        !o_chain_out_n [*6] ##[1:4] o_chain_out_n) else $error("chain low span wrong");
    rx_after_fall_a: assert property ($rose(o_rx_valid) |->
        !$past(i_sclk, 1) && !$past(i_sclk, 2)) else $error("byte taken off a fall");
    fault_pull_a: assert property (i_input_fault |=> o_fault_n_oe && !o_fault_n_o)
        else $error("fault line not pulled");
    fault_free_a: assert property (!i_input_fault |=> !o_fault_n_oe)
        else $error("fault line pulled without cause");
    ovr_pull_a: assert property (i_result_over_range || i_input_fault |=>
        o_result_over_range_n_oe && !o_result_over_range_n_o) else $error("overflow line not pulled");
    ovr_free_a: assert property (!i_result_over_range && !i_input_fault |=>
        !o_result_over_range_n_oe) else $error("overflow line pulled without cause");
    osc_copy_a: assert property (i_crystal_enable && i_crystal_fitted |->
        o_buffered_osc_out_oe && o_buffered_osc_out == i_osc_clk) else $error("clock copy wrong");
    osc_off_a: assert property (!i_crystal_enable |-> !o_buffered_osc_out_oe)
        else $error("clock output driven while disabled");
endmodule // csp_port_checker

bind csp_port csp_port_checker i_chk (
    .i_mclk                   (i_mclk),
    .i_sys_rst                (i_sys_rst),
    .i_sclk                   (i_sclk),
    .i_cs_n                   (i_cs_n),
    .i_input_fault            (i_input_fault),
    .i_result_over_range      (i_result_over_range),
    .i_osc_clk                (i_osc_clk),
    .i_crystal_enable         (i_crystal_enable),
    .i_crystal_fitted         (i_crystal_fitted),
    .o_dout_oe                (o_dout_oe),
    .o_chain_out_n            (o_chain_out_n),
    .o_rx_valid               (o_rx_valid),
    .o_fault_n_o              (o_fault_n_o),
    .o_fault_n_oe             (o_fault_n_oe),
    .o_result_over_range_n_oe (o_result_over_range_n_oe),
    .o_result_over_range_n_o  (o_result_over_range_n_o),
    .o_buffered_osc_out       (o_buffered_osc_out),
    .o_buffered_osc_out_oe    (o_buffered_osc_out_oe)
);

// ### csp_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host and chain neighbour: drives the pins, 80 ns serial clock.
// ----------------------------------------------------------------
module csp_host_model (
    output reg  o_sclk, o_cs_n, o_din, o_chain_in_n,
    input  wire i_dout, i_dout_oe, i_chain_out_n
);
    reg  last;
    // A released output shows the inverse of its last level, never a copy.
    wire line = i_dout_oe ? i_dout : ~last;
    initial begin
        {o_sclk, o_cs_n, o_din, o_chain_in_n, last} = 5'h1e;
    end
    // Chain input is set first so the select edge sees it settled.
    task sel(input cs, input ch);
        begin
            o_chain_in_n = ch;
            #20 o_cs_n = cs;
            #60;
        end
    endtask
    // One byte, MSB first; output is read just before the next rise.
    task xbyte(input [7:0] tx, input cin, output [7:0] rx, output co);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                o_din = tx[i];
                if (i == 0) o_chain_in_n = cin;
                #40 o_sclk = 1'b0;
                #40 rx[i] = line;
                last = line;
                if (i == 0) co = i_chain_out_n;
                o_sclk = 1'b1;
            end
        end
    endtask
endmodule // csp_host_model

// ### csp_port_tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bench: host model moves bytes, queues hold the expected bytes.
// ----------------------------------------------------------------
module csp_port_tb;
    reg         i_mclk, i_sys_rst, i_cmd_start, tk, co;
    reg         i_input_fault, i_result_over_range, i_osc_clk;
    reg         i_crystal_enable, i_crystal_fitted;
    reg  [7:0]  i_tx_byte, r;
    reg  [31:0] seed;
    wire        sclk, cs_n, din, chain_in_n, dout, dout_oe, chain_out_n;
    wire        o_tx_take, o_rx_valid;
    wire [7:0]  o_rx_byte;
    integer     mismatches, n_checks, cyc, w, b;
    logic [7:0] txq[$], rxq[$];
    csp_port i_dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_din(din), .i_chain_in_n(chain_in_n), .i_cmd_start(i_cmd_start),
        .i_tx_byte(i_tx_byte), .o_tx_take(o_tx_take), .o_rx_byte(o_rx_byte),
        .o_rx_valid(o_rx_valid), .o_dout(dout), .o_dout_oe(dout_oe),
        .o_chain_out_n(chain_out_n), .i_input_fault(i_input_fault),
        .i_result_over_range(i_result_over_range), .o_fault_n_o(), .o_fault_n_oe(),
        .o_result_over_range_n_o(), .o_result_over_range_n_oe(), .i_osc_clk(i_osc_clk),
        .i_crystal_enable(i_crystal_enable), .i_crystal_fitted(i_crystal_fitted),
        .o_buffered_osc_out(), .o_buffered_osc_out_oe());
    csp_host_model i_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din),
        .o_chain_in_n(chain_in_n), .i_dout(dout), .i_dout_oe(dout_oe),
        .i_chain_out_n(chain_out_n));
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input [7:0] e, input [7:0] g);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("wrong value t=%0t exp=%h got=%h", $time, e, g);
            end
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", n_checks, mismatches);
            if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // Moves one byte; a byte the port should take is noted beforehand.
    task xb(input [7:0] d, input cin, input take, input last_b);
        begin
            if (take) rxq.push_back(d);
            i_host.xbyte(d, cin, r, co);
            chk({7'h0, !last_b}, {7'h0, co});
            if (take) chk(txq.pop_front(), r);
        end
    endtask
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    // Status inputs wander every cycle so the pin checks see every case.
    always @(posedge i_mclk) begin
        tk = o_tx_take;
        if (tk === 1'b1) txq.push_back(i_tx_byte);
        #1;
        seed = lfsr(seed);
        {i_input_fault, i_result_over_range, i_osc_clk} = seed[2:0];
        {i_crystal_enable, i_crystal_fitted} = seed[4:3];
        if (tk === 1'b1) i_tx_byte = seed[15:8];
        cyc = cyc + 1;
        if (cyc == 5000) begin
            mismatches = mismatches + 1;
            stop_test;
        end
    end
    // A received byte with no note pending means input was not ignored.
    always @(posedge i_mclk) begin
        if (o_rx_valid === 1'b1 && rxq.size() == 0) chk(8'h00, 8'h01);
        else if (o_rx_valid === 1'b1) chk(rxq.pop_front(), o_rx_byte);
    end
    initial begin
        {i_sys_rst, i_cmd_start, i_input_fault, i_result_over_range} = 4'h8;
        {i_osc_clk, i_crystal_enable, i_crystal_fitted, tk, co} = 5'h00;
        {i_tx_byte, seed, mismatches, n_checks, cyc} = {8'h5a, 32'h25cb, 96'h0};
        repeat (4) @(posedge i_mclk);
        #1 i_sys_rst = 1'b0;
        // Pass 0 starts on the select edge, pass 1 waits for the chain.
        for (w = 0; w < 2; w = w + 1) begin
            @(posedge i_mclk);
            #1 i_cmd_start = 1'b1;
            @(posedge i_mclk);
            #1 i_cmd_start = 1'b0;
            txq.delete();
            i_host.sel(1'b0, w[0]);
            if (w == 1) chk({7'h0, dout_oe}, 8'h00);
            if (w == 1) xb(seed[23:16], 1'b0, 1'b0, 1'b0);
            // The chain fall has enabled the driver before the byte end is seen.
            if (w == 1) chk({7'h0, dout_oe}, 8'h01);
            for (b = 0; b < 4; b = b + 1) xb(seed[23:16], 1'b0, 1'b1, b == 3);
            xb(seed[23:16], 1'b0, 1'b0, 1'b0);
            chk({7'h0, dout_oe}, 8'h00);
            // A new command rearms the port once the last rise has been seen.
            repeat (5) @(posedge i_mclk);
            #1 i_cmd_start = 1'b1;
            @(posedge i_mclk);
            #1 i_cmd_start = 1'b0;
            xb(seed[23:16], 1'b0, 1'b0, 1'b0);
            #50;
            chk({7'h0, dout_oe}, 8'h01);
            // Deselecting in mid transfer must release the driver.
            i_host.sel(1'b1, 1'b1);
            xb(seed[23:16], 1'b1, 1'b0, 1'b0);
            chk({7'h0, dout_oe}, 8'h00);
        end
        chk(rxq.size(), 8'h00);
        stop_test;
    end
endmodule // csp_port_tb
